/* verilog/prl_map.svh */
`ifndef PRL_MAP_SVH
`define PRL_MAP_SVH

// Image word width and address width of the image store
`define PRL_WORD_W 32
`define PRL_ADDR_W 24
`define PRL_LEN_W 24

// Command word that closes a partial image when reset-after-reconfig is off
`define PRL_END_OF_SYNC_WORD 32'h0000000d

// Reset values
`define PRL_WORD_RST 32'h00000000
`define PRL_ADDR_RST 24'h000000
`define PRL_LEN_RST 24'h000000
`define PRL_SYNC_RST 3'h0

`endif

/* verilog/prl_pkg.sv */
`include "prl_map.svh"

package prl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_WAIT,
        ST_PUSH,
        ST_FINISH,
        ST_FAIL
    } prl_state_t;

    // Word offered to the internal configuration port
    typedef struct packed {
        logic [`PRL_WORD_W-1:0] data;
        logic write_en;
    } prl_cfg_word_t;

    // Read request towards the image store
    typedef struct packed {
        logic [`PRL_ADDR_W-1:0] addr;
        logic req;
    } prl_mem_req_t;

endpackage

/* verilog/prl_loader.sv */
// Behaviour
// - Persisted config pins disable internal port
// - Loader keeps running during reconfiguration
// - Corrupt image: complete never asserted
// - Complete low at start, high on success
// - Clearing image keeps complete low afterwards
// - Padding precedes end-of-sync; data already landed
// - Signal mask opened only by images
// - Partial image: header, frames, checksum only
// - Optional integrity checks; region auto-initialised
// - Device stays in user mode while loading
// - Image carries its own frame addresses
`timescale 1ns/1ps
`include "prl_map.svh"

module prl_loader #(
    parameter int WORD_W = `PRL_WORD_W,
    parameter int ADDR_W = `PRL_ADDR_W,
    parameter int LEN_W = `PRL_LEN_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [ADDR_W-1:0] image_base,
    input wire logic [LEN_W-1:0] image_words,
    input wire logic reset_after_reconfig,
    input wire logic image_is_clearing,
    input wire logic keep_config_pins_property,
    output prl_pkg::prl_mem_req_t mem_req,
    input wire logic mem_valid,
    input wire logic [WORD_W-1:0] mem_data,
    output prl_pkg::prl_cfg_word_t internal_config_port,
    input wire logic port_ready,
    input wire logic checksum_error,
    output logic config_complete,
    output logic region_isolate,
    output logic region_release,
    output logic load_busy,
    output logic load_error,
    output logic port_disabled
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap synchroniser for the pin-persist option

    logic [2:0] persist_sync_r;
    logic persist_r;

    // Comes from pins outside our clock, so three stages before use
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            persist_sync_r <= `PRL_SYNC_RST;
        else
            persist_sync_r <= {persist_sync_r[1:0], keep_config_pins_property};
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            persist_r <= 1'b0;
        else if (persist_sync_r[1] == persist_sync_r[2])
            persist_r <= persist_sync_r[2];
    end

    assign port_disabled = persist_r;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    prl_pkg::prl_state_t state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [LEN_W-1:0] left_r;
    logic [WORD_W-1:0] word_r;
    logic rar_r;
    logic clearing_r;
    logic last_word;
    logic end_seen;
    logic accept;
    logic take;

    assign accept = (state_r == prl_pkg::ST_PUSH) && port_ready;
    // One condition for every capture, so a refused start leaves no trace behind
    assign take = start && !load_busy && !persist_r && (image_words != '0);
    assign last_word = (left_r == LEN_W'(1));
    // Without reset-after-reconfig the end-of-sync word is the finish marker
    assign end_seen = !rar_r && (word_r == WORD_W'(`PRL_END_OF_SYNC_WORD));

    // One word in flight at a time; the loader never stalls on the region
    // being rebuilt because it sits entirely in static logic
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= prl_pkg::ST_IDLE;
        else
        begin
            unique case (state_r)
                prl_pkg::ST_IDLE,
                prl_pkg::ST_FINISH,
                prl_pkg::ST_FAIL:
                    // Start is ignored while the port is given to the pins
                    if (take)
                        state_r <= prl_pkg::ST_FETCH;
                prl_pkg::ST_FETCH:
                    state_r <= prl_pkg::ST_WAIT;
                prl_pkg::ST_WAIT:
                    if (mem_valid)
                        state_r <= prl_pkg::ST_PUSH;
                prl_pkg::ST_PUSH:
                    if (checksum_error)
                        state_r <= prl_pkg::ST_FAIL;
                    else if (accept && (last_word || end_seen))
                        state_r <= prl_pkg::ST_FINISH;
                    else if (accept)
                        state_r <= prl_pkg::ST_FETCH;
            endcase
        end
    end

    // Address walks the image strictly in stored order
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_r <= ADDR_W'(`PRL_ADDR_RST);
            left_r <= LEN_W'(`PRL_LEN_RST);
        end
        else if (take)
        begin
            addr_r <= image_base;
            left_r <= image_words;
        end
        else if (accept)
        begin
            addr_r <= addr_r + ADDR_W'(1);
            left_r <= left_r - LEN_W'(1);
        end
    end

    // Fetched word is held until the port takes it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            word_r <= WORD_W'(`PRL_WORD_RST);
        else if (state_r == prl_pkg::ST_WAIT && mem_valid)
            word_r <= mem_data;
    end

    // Completion style and image kind are caught at start
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rar_r <= 1'b0;
            clearing_r <= 1'b0;
        end
        else if (take)
        begin
            rar_r <= reset_after_reconfig;
            clearing_r <= image_is_clearing;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port and memory drive

    assign load_busy = (state_r == prl_pkg::ST_FETCH) || (state_r == prl_pkg::ST_WAIT)
        || (state_r == prl_pkg::ST_PUSH);

    // Memory request is a one-cycle pulse per word
    always_comb
    begin
        mem_req.addr = `PRL_ADDR_W'(addr_r);
        mem_req.req = (state_r == prl_pkg::ST_FETCH);
    end

    // Write enable is a handshake term; data comes from a flop
    always_comb
    begin
        // Words pass unchanged, so only the image itself opens the signal mask
        internal_config_port.data = `PRL_WORD_W'(word_r);
        internal_config_port.write_en = (state_r == prl_pkg::ST_PUSH) && !persist_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion, isolation and release

    logic complete_r;
    logic isolate_r;
    logic release_r;
    logic error_r;
    logic first_r;

    // Complete drops when a load begins; a clearing image never raises it,
    // so a clearing + partial pair shows one low stretch
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            complete_r <= 1'b0;
        else if (state_r == prl_pkg::ST_FETCH && first_r)
            complete_r <= 1'b0;
        else if (state_r == prl_pkg::ST_PUSH && checksum_error)
            complete_r <= 1'b0;
        else if (state_r == prl_pkg::ST_PUSH && accept && (last_word || end_seen))
            complete_r <= !clearing_r;
    end

    // Region outputs stay isolated from the first word until a real image ends
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            isolate_r <= 1'b0;
        else if (load_busy)
            isolate_r <= 1'b1;
        else if (state_r == prl_pkg::ST_FINISH && !clearing_r)
            isolate_r <= 1'b0;
    end

    // Release is a pulse after a whole non-clearing image went in, never after a fail
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            release_r <= 1'b0;
        else
            release_r <= accept && (last_word || end_seen) && !checksum_error
                && !clearing_r;
    end

    // Error stays set until the next load starts
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            error_r <= 1'b0;
        else if (state_r == prl_pkg::ST_PUSH && checksum_error)
            error_r <= 1'b1;
        else if (state_r == prl_pkg::ST_FETCH)
            error_r <= 1'b0;
    end

    // Marks the first fetch of a load: remaining count still untouched
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            first_r <= 1'b0;
        else if (take)
            first_r <= 1'b1;
        else if (state_r == prl_pkg::ST_FETCH)
            first_r <= 1'b0;
    end

    assign config_complete = complete_r;
    assign region_isolate = isolate_r;
    assign region_release = release_r;
    assign load_error = error_r;

endmodule

/* sim/prl_loader_asserts.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the loader, all held off while reset is low
module prl_loader_asserts (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [23:0] image_base,
    input wire logic [23:0] image_words,
    input wire prl_pkg::prl_mem_req_t mem_req,
    input wire prl_pkg::prl_cfg_word_t internal_config_port,
    input wire logic port_ready,
    input wire logic checksum_error,
    input wire logic config_complete,
    input wire logic region_isolate,
    input wire logic region_release,
    input wire logic load_busy,
    input wire logic load_error,
    input wire logic port_disabled
);
    logic acc;

    // A word counts as delivered only when the engine took it without a fault
    assign acc = internal_config_port.write_en && port_ready && !checksum_error;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_take;
        start && !load_busy && !port_disabled && image_words != 24'h0;
    endsequence
    sequence s_next;
        acc ##1 mem_req.req;
    endsequence

    a_start_fetch: assert property (s_take |=> mem_req.req && mem_req.addr == $past(image_base))
        else $error("no fetch of the base word after start");
    a_req_pulse: assert property (mem_req.req |=> !mem_req.req)
        else $error("read request longer than one cycle");
    a_word_hold: assert property (internal_config_port.write_en && !port_ready && !checksum_error
        |=> internal_config_port.write_en && $stable(internal_config_port.data))
        else $error("word dropped or changed before acceptance");
    a_addr_step: assert property (s_next |-> mem_req.addr == $past(mem_req.addr) + 24'h1)
        else $error("next fetch not at the following address");
    a_busy_isolate: assert property (load_busy && $past(load_busy)
        |-> !config_complete && region_isolate)
        else $error("region not isolated or complete high while loading");
    a_release_pulse: assert property (region_release |=> !region_release)
        else $error("release longer than one cycle");
    a_release_cause: assert property (region_release |-> $past(acc) || $past(acc, 2))
        else $error("release without a final accepted word");
    a_release_done: assert property (region_release
        |-> ##[0:2] (config_complete && !region_isolate))
        else $error("complete not raised after release");
    a_error_quiet: assert property (load_error |-> !config_complete && !region_release)
        else $error("complete or release after a corrupt image");
    a_disabled_idle: assert property (port_disabled && !load_busy |=> !load_busy)
        else $error("load started with the port disabled");
endmodule

bind prl_loader prl_loader_asserts i_chk (.clock, .rst_n, .start, .image_base, .image_words,
    .mem_req, .internal_config_port, .port_ready, .checksum_error, .config_complete,
    .region_isolate, .region_release, .load_busy, .load_error, .port_disabled);

/* sim/prl_engine_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Image store and configuration engine; both answer after random delays
module prl_engine_model (
    input wire logic clock,
    input wire prl_pkg::prl_mem_req_t mem_req,
    input wire prl_pkg::prl_cfg_word_t internal_config_port,
    input wire logic err_en,
    output logic mem_valid,
    output logic [31:0] mem_data,
    output logic port_ready,
    output logic checksum_error
);
    logic [1:0] cnt_r = 2'h0;
    logic [31:0] word_r = 32'h0;

    // Outputs are unknown only before the first falling edge, while reset holds
    // Data line shows garbage outside valid so stale words cannot pass
    assign mem_data = mem_valid ? word_r : ~word_r;
    assign checksum_error = err_en & internal_config_port.write_en;

    // Low byte 3f holds the end-of-sync command, padding before it is plain
    always @(negedge clock)
    begin
        mem_valid <= (cnt_r == 2'h1);
        // Engine only takes words pushed to it and never fetches an image itself
        port_ready <= 1'($urandom_range(1, 0));
        if (mem_req.req)
        begin
            cnt_r <= 2'($urandom_range(3, 1));
            word_r <= (mem_req.addr[7:0] == 8'h3f) ? 32'hd : {8'ha5, mem_req.addr};
        end
        else if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
    end
endmodule

/* sim/prl_loader_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module prl_loader_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic reset_after_reconfig = 1'b0;
    logic image_is_clearing = 1'b0;
    logic keep_config_pins_property = 1'b0;
    logic err_en = 1'b0;
    logic [23:0] image_base = 24'h0;
    logic [23:0] image_words = 24'h0;
    logic mem_valid, port_ready, checksum_error;
    logic config_complete, region_isolate, region_release, load_busy, load_error, port_disabled;
    logic [31:0] mem_data, w;
    prl_pkg::prl_mem_req_t mem_req;
    prl_pkg::prl_cfg_word_t internal_config_port;
    logic [31:0] exp_q[$];
    int failures = 0;
    int check_count = 0;
    int rel_n = 0;
    int cyc = 0;

    always #5 clock = ~clock;

    prl_loader i_dut (.clock, .rst_n, .start, .image_base, .image_words, .reset_after_reconfig,
        .image_is_clearing, .keep_config_pins_property, .mem_req, .mem_valid, .mem_data,
        .internal_config_port, .port_ready, .checksum_error, .config_complete, .region_isolate,
        .region_release, .load_busy, .load_error, .port_disabled);
    prl_engine_model i_eng (.clock, .mem_req, .internal_config_port, .err_en, .mem_valid,
        .mem_data, .port_ready, .checksum_error);

    task final_report();
        $display("failures %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Each accepted word must be the oldest one noted; also cuts a hang short
    always @(posedge clock)
    begin
        cyc++;
        if (region_release === 1'b1)
            rel_n++;
        if (internal_config_port.write_en && port_ready && !checksum_error)
        begin
            w = exp_q.size() ? exp_q.pop_front() : 32'hx;
            `CHK("word", w, internal_config_port.data)
        end
        if (cyc > 20000)
        begin
            failures++;
            final_report();
        end
    end

    // Start one load, note the words it should deliver, wait for it to end
    task run(input logic [23:0] b, input logic [23:0] n, input logic rar, input logic clr,
        input int nexp, input int nrel);
        int k, r;
        logic [23:0] a;
        r = rel_n;
        @(negedge clock);
        image_base = b;
        image_words = n;
        reset_after_reconfig = rar;
        image_is_clearing = clr;
        start = 1'b1;
        for (k = 0; k < nexp; k++)
        begin
            a = b + 24'(k);
            exp_q.push_back((a[7:0] == 8'h3f) ? 32'hd : {8'ha5, a});
        end
        @(negedge clock);
        start = 1'b0;
        // A hang is cut short by the cycle ceiling in the monitor
        while (load_busy !== 1'b0)
        begin
            @(negedge clock);
        end
        repeat (3) @(negedge clock);
        `CHK("words left", 0, exp_q.size())
        `CHK("releases", nrel, rel_n - r)
    endtask

    initial
    begin
        void'($urandom(32'h288c));
        repeat (6) @(negedge clock);
        // Released once; nothing resets the device after the first image
        rst_n = 1'b1;
        run({8'h00, 8'($urandom), 8'h00}, 24'h5, 1'b1, 1'b0, 5, 1);
        `CHK("complete", 1'b1, config_complete)
        `CHK("isolate", 1'b0, region_isolate)
        // End-of-sync closes an image that claims more words, but not with reset-after-reconfig
        run(24'h30, 24'h20, 1'b0, 1'b0, 16, 1);
        run(24'h30, 24'h12, 1'b1, 1'b0, 18, 1);
        // Clearing image keeps complete low until the partial image ends
        run(24'h100, 24'h3, 1'b1, 1'b1, 3, 0);
        `CHK("complete", 1'b0, config_complete)
        `CHK("isolate", 1'b1, region_isolate)
        run(24'h200, 24'h4, 1'b1, 1'b0, 4, 1);
        `CHK("complete", 1'b1, config_complete)
        err_en = 1'b1;
        run(24'h300, 24'h4, 1'b1, 1'b0, 0, 0);
        err_en = 1'b0;
        `CHK("error", 1'b1, load_error)
        `CHK("complete", 1'b0, config_complete)
        run(24'h400, 24'h0, 1'b1, 1'b0, 0, 0);
        // Persisted pins shut the port; a start must be ignored
        keep_config_pins_property = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("disabled", 1'b1, port_disabled)
        run(24'h500, 24'h2, 1'b1, 1'b0, 0, 0);
        `CHK("error", 1'b1, load_error)
        final_report();
    end
endmodule
